// ===== shared/rss_defs.svh
/*
  Constants of the readout set-up sequencer: device register offsets,
  field positions, recommended values and command codes.
  Assumes it is included by its bare name from the package and modules.
*/
// Functional notes
// R01: issue a global reset command before any configuration write.
// R02: have the pixel pulse-allow and mask latches initialised every time.
// R03: run the transmitter start-up only for inner or outer master chips.
// R04: program oscillator stage count and bandwidth; nominal four, narrow.
// R05: program charge pump current to a valid value, nominal 4'b1000.
// R06: clear power-off, then set and clear PLL reset, other bits unchanged.
// R07: chips take the bus token after predecessor header and trailer.
// R08: only one chip of a module may carry the first-in-chain flag.
// R09: a written first-in-chain flag waits for readout reset to act.
// R10: inner chips may keep predecessor 4'b1111 and first-in-chain zero.
// R11: slice mask bit zero masks storage slice zero.
// R12: continuous internal windows start on a trigger, later ones re-time.
// R13: test pulse mode zero gives digital pulse, one gives analog pulse.
// R14: with test window enabled also program both pulsing registers.
// R15: window length counts in main clock periods of 25 ns.
// R16: chip mode 2'b01 triggered, 2'b10 continuous; write enters readout.
// R17: readout speed one gives 20 kHz, zero gives 10 kHz.
// R18: link speed 0 400 Mbps, 1 600 Mbps, 2 or 3 1200 Mbps.
// R19: mode register write last, then readout reset, then triggers.
// R20: readout reset commits first-in-chain; token holder drives the bus.
// R21: load-outer-default writes master plus six slaves chain settings.
// R22: load-outer-default is followed by an automatic readout reset.
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// ----------------------------------------------------------------------
// device register offsets
// ----------------------------------------------------------------------
`define RSS_REG_MODE_CTRL   16'h0001
`define RSS_REG_STRB_CFG1   16'h0004
`define RSS_REG_STRB_CFG2   16'h0005
`define RSS_REG_PULSE_CFG1  16'h0007
`define RSS_REG_PULSE_CFG2  16'h0008
`define RSS_REG_CHAIN_CFG   16'h0010
`define RSS_REG_TX_CFG      16'h0014
`define RSS_REG_TX_DACS     16'h0015

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RSS_TX_STAGES_LSB   0
`define RSS_TX_BW_BIT       2
`define RSS_TX_PLL_OFF_BIT  3
`define RSS_TX_PLL_RST_BIT  8
`define RSS_DAC_CP_LSB      0
`define RSS_DAC_LINE_LSB    4
`define RSS_DAC_PRE_LSB     8
`define RSS_CH_PRED_LSB     0
`define RSS_CH_FIRST_BIT    4
`define RSS_S1_MASK_LSB     0
`define RSS_S1_INTSTRB_BIT  3
`define RSS_S1_BUSYMON_BIT  4
`define RSS_S1_PMODE_BIT    5
`define RSS_S1_TWIN_BIT     6
`define RSS_MD_MODE_LSB     0
`define RSS_MD_CLUSTER_BIT  2
`define RSS_MD_SPEED_BIT    3
`define RSS_MD_LINK_LSB     4

// ----------------------------------------------------------------------
// recommended values
// ----------------------------------------------------------------------
`define RSS_NOM_STAGES      2'h1
`define RSS_NOM_CP          4'h8
`define RSS_PRED_NONE       4'hF
`define RSS_MODE_TRIG       2'h1
`define RSS_MODE_CONT       2'h2
`define RSS_WIN_STEP_NS     25

// ----------------------------------------------------------------------
// command codes (values on the command lane)
// ----------------------------------------------------------------------
`define RSS_CMD_GLOBAL_RST  8'hD2
`define RSS_CMD_RO_RST      8'h63
`define RSS_CMD_LOAD_OUTER  8'hC0

`endif

// ===== shared/rss_pkg.sv
/*
  Types of the readout set-up sequencer.
  Assumes rss_defs.svh is reachable on the include path.
*/
`include "rss_defs.svh"
package rss_pkg;

  // ----------------------------------------------------------------------
  // chip role and sequence steps
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSS_ROLE_INNER  = 2'h0,
    RSS_ROLE_MASTER = 2'h1,
    RSS_ROLE_SLAVE  = 2'h2
  } rss_role_t;

  typedef enum logic [3:0] {
    RSS_ST_IDLE     = 4'h0,
    RSS_ST_GRST     = 4'h1,
    RSS_ST_PIXINIT  = 4'h2,
    RSS_ST_TXDAC    = 4'h3,
    RSS_ST_TXCFG    = 4'h4,
    RSS_ST_PLLSET   = 4'h5,
    RSS_ST_PLLCLR   = 4'h6,
    RSS_ST_CHAIN    = 4'h7,
    RSS_ST_STRB1    = 4'h8,
    RSS_ST_STRB2    = 4'h9,
    RSS_ST_PULSE1   = 4'hA,
    RSS_ST_PULSE2   = 4'hB,
    RSS_ST_MODE     = 4'hC,
    RSS_ST_READOUT_RESET_COMMAND    = 4'hD,
    RSS_ST_READY    = 4'hE
  } rss_state_t;

endpackage : rss_pkg

// ===== tb/rss_device_model.sv
/*
  Behavioural chip: register file, commands, chain token, and an
  acknowledge after a settable wait.
  Assumes one access at a time from the host port.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rss_defs.svh"
module rss_device_model
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  ack_delay,
  input  wire logic [3:0]  chip_identifier,
  input  wire logic        dev_req,
  input  wire logic        dev_is_cmd,
  input  wire logic [15:0] dev_addr,
  input  wire logic [15:0] dev_data,
  output logic             dev_ack
);
  logic [15:0] regs [0:31];
  logic [3:0]  wait_cnt;
  logic        token;
  logic [32:0] log_q [$];
  wire logic   master = chip_identifier == 4'h0;
  wire logic   is_cmd = dev_req && dev_ack && dev_is_cmd;
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dev_ack  <= 1'b0;
      wait_cnt <= 4'h0;
      token    <= 1'b0;
    end
    else if (dev_req && dev_ack)
    begin
      dev_ack  <= 1'b0;
      wait_cnt <= 4'h0;
      // a global reset starts a fresh access log and chain defaults
      if (is_cmd && dev_data[7:0] == `RSS_CMD_GLOBAL_RST)
      begin
        log_q.delete();
        regs[16] <= 16'h000F;
      end
      log_q.push_back(dev_is_cmd ? {1'b1, 24'h0, dev_data[7:0]}
                                 : {1'b0, dev_addr, dev_data});
      if (!dev_is_cmd)
        regs[dev_addr[4:0]] <= dev_data;
      if (is_cmd && dev_data[7:0] == `RSS_CMD_RO_RST)
        token <= regs[16][4];
      if (is_cmd && dev_data[7:0] == `RSS_CMD_LOAD_OUTER)
      begin
        regs[16] <= {11'h0, master,
                     master ? 4'hF : chip_identifier - 4'h1};
        token    <= master;
      end
    end
    else if (dev_req)
    begin
      if (wait_cnt == ack_delay)
        dev_ack <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : rss_device_model
`default_nettype wire

// ===== tb/rss_sequencer_bench.sv
/*
  Bench of the readout set-up sequencer: bring-up runs per chip role
  against the behavioural chip, every access compared.
  Assumes design, checker and chip model are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rss_defs.svh"
module rss_sequencer_bench;
  import rss_pkg::*;
  logic        sys_clk = 1'b0, rst_b = 1'b0, start = 1'b0;
  logic        use_load_outer = 1'b0, loop_bw_wide = 1'b0, clustering = 1'b1;
  logic        first_in_chain = 1'b1, internal_windows = 1'b1;
  logic        test_pulse_analog = 1'b0, test_window_enable = 1'b0;
  logic        readout_fast = 1'b0, pix_init_done = 1'b0;
  logic        busy, ready_for_triggers, config_error, pix_init_req;
  logic        dev_req, dev_is_cmd, dev_ack;
  logic [1:0]  osc_stages = 2'h1, chip_mode = 2'h1, link_speed = 2'h0;
  logic [2:0]  event_slice_mask = 3'h5;
  logic [3:0]  pump_current = 4'h0, line_current = 4'h6, pre_current = 4'h3;
  logic [3:0]  predecessor_identifier = 4'h5, ack_delay = 4'h0;
  logic [3:0]  chip_identifier = 4'h2;
  logic [15:0] window_length = 16'h0028, pulse_delay = 16'h0011;
  logic [15:0] pulse_length = 16'h0009, dev_addr, dev_data;
  rss_role_t   role = RSS_ROLE_INNER;
  int          n_errors, tests_run, cycles;
  rss_sequencer    i_dut (.*);
  rss_device_model i_dev (.*);
  initial
    forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      test_done;
    end
  end
  task automatic check(string what, logic [32:0] exp, logic [32:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // start one bring-up, serve the pixel loader, compare every access
  task automatic run_check(logic exp_token);
    logic [32:0] q [$];
    logic [15:0] c;
    logic        inner;
    int          k;
    inner = role == RSS_ROLE_INNER;
    c = {12'h0, 1'b0, loop_bw_wide, osc_stages};
    q.push_back({1'b1, 24'h0, `RSS_CMD_GLOBAL_RST});
    if (role != RSS_ROLE_SLAVE)
    begin
      q.push_back({1'b0, `RSS_REG_TX_DACS, 4'h0, pre_current, line_current,
                   pump_current == 4'h0 ? 4'h8 : pump_current});
      q.push_back({1'b0, `RSS_REG_TX_CFG, c});
      q.push_back({1'b0, `RSS_REG_TX_CFG, c | 16'h0100});
      q.push_back({1'b0, `RSS_REG_TX_CFG, c});
    end
    if (use_load_outer)
      q.push_back({1'b1, 24'h0, `RSS_CMD_LOAD_OUTER});
    else
      q.push_back({1'b0, `RSS_REG_CHAIN_CFG, 11'h0, first_in_chain && !inner,
                   inner ? 4'hF : predecessor_identifier});
    q.push_back({1'b0, `RSS_REG_STRB_CFG1, 9'h0, test_window_enable,
                 test_pulse_analog, 1'b1, internal_windows && chip_mode == 2'h2,
                 event_slice_mask});
    q.push_back({1'b0, `RSS_REG_STRB_CFG2, window_length});
    if (test_window_enable)
    begin
      q.push_back({1'b0, `RSS_REG_PULSE_CFG1, pulse_delay});
      q.push_back({1'b0, `RSS_REG_PULSE_CFG2, pulse_length});
    end
    q.push_back({1'b0, `RSS_REG_MODE_CTRL, 10'h0, link_speed, readout_fast,
                 clustering, chip_mode});
    q.push_back({1'b1, 24'h0, `RSS_CMD_RO_RST});
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    for (k = 0; k < 300 && pix_init_req !== 1'b1; k++)
      @(negedge sys_clk);
    check("pixel init after reset", 33'h5,
          {31'(i_dev.log_q.size()), 1'b0, pix_init_req});
    repeat (3) @(negedge sys_clk);
    pix_init_done = 1'b1;
    @(negedge sys_clk);
    pix_init_done = 1'b0;
    for (k = 0; k < 1000 && ready_for_triggers !== 1'b1; k++)
      @(negedge sys_clk);
    check("ready and busy", 33'h2,
          {30'h0, config_error, ready_for_triggers, busy});
    check("access count", 33'(q.size()), 33'(i_dev.log_q.size()));
    foreach (q[i])
      if (i < i_dev.log_q.size())
        check("device access", q[i], i_dev.log_q[i]);
    check("chain token", {32'h0, exp_token}, {32'h0, i_dev.token});
  endtask : run_check
  task automatic sc_inner;
    run_check(1'b0);
  endtask : sc_inner
  task automatic sc_master_window;
    role = RSS_ROLE_MASTER;
    chip_mode = 2'h2;
    test_window_enable = 1'b1;
    test_pulse_analog = 1'b1;
    pump_current = 4'h9;
    link_speed = 2'h1;
    readout_fast = 1'b1;
    ack_delay = 4'h3;
    loop_bw_wide = 1'b1;
    osc_stages = 2'h3;
    run_check(1'b1);
  endtask : sc_master_window
  task automatic sc_slave_load_outer;
    role = RSS_ROLE_SLAVE;
    use_load_outer = 1'b1;
    chip_identifier = 4'h0;
    ack_delay = 4'h1;
    link_speed = 2'h3;
    run_check(1'b1);
  endtask : sc_slave_load_outer
  task automatic sc_bad_mode;
    chip_mode = 2'h0;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("illegal mode refused", 33'h2, {31'h0, config_error, busy});
  endtask : sc_bad_mode
  initial
  begin
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    sc_inner;
    sc_master_window;
    sc_slave_load_outer;
    sc_bad_mode;
    test_done;
  end
endmodule : rss_sequencer_bench
`default_nettype wire

// ===== tb/rss_sequencer_checker.sv
/*
  Port assertions of the readout set-up sequencer, bound to rss_sequencer.
  Assumes rss_defs.svh and rss_pkg are compiled before this file.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rss_defs.svh"
module rss_sequencer_checker
(
  input wire logic               sys_clk,
  input wire logic               rst_b,
  input wire rss_pkg::rss_role_t role,
  input wire logic [1:0]         chip_mode,
  input wire logic [2:0]         event_slice_mask,
  input wire logic               test_pulse_analog,
  input wire logic               test_window_enable,
  input wire logic               busy,
  input wire logic               ready_for_triggers,
  input wire logic               dev_req,
  input wire logic               dev_is_cmd,
  input wire logic [15:0]        dev_addr,
  input wire logic [15:0]        dev_data,
  input wire logic               dev_ack
);
  import rss_pkg::*;
  wire logic   wr = dev_req && !dev_is_cmd;
  wire logic   done = dev_req && dev_ack;
  logic [15:0] pll_word;
  // last accepted word, so the reset-clear write can be matched to it
  always_ff @(posedge sys_clk)
    if (done)
      pll_word <= dev_data;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_GRST_FIRST: assert property ($rose(busy) |-> ##[1:4]
    (dev_req && dev_is_cmd && dev_data[7:0] == `RSS_CMD_GLOBAL_RST))
    else $error("sequence did not open with a global reset");
  AST_READOUT_RESET_COMMAND_READY: assert property (done && dev_is_cmd
    && dev_data[7:0] == `RSS_CMD_RO_RST |-> ##[1:4] ready_for_triggers)
    else $error("readout reset not followed by ready");
  AST_HOLD: assert property (dev_req && !dev_ack |=> dev_req
    && $stable(dev_addr) && $stable(dev_data))
    else $error("access changed before acknowledge");
  AST_GAP: assert property (done |=> (!dev_req) [*2])
    else $error("accesses too close");
  AST_PLL_PAIR: assert property (done && !dev_is_cmd
    && dev_addr == `RSS_REG_TX_CFG && dev_data[8] |-> ##[2:4]
    (wr && dev_addr == `RSS_REG_TX_CFG && dev_data == (pll_word & 16'hFEFF)))
    else $error("pll reset not cleared with other bits kept");
  AST_TWIN: assert property (wr && (dev_addr == `RSS_REG_PULSE_CFG1
    || dev_addr == `RSS_REG_PULSE_CFG2) |-> test_window_enable)
    else $error("pulsing register written without test window");
  AST_CFG1: assert property (wr
    && dev_addr == `RSS_REG_STRB_CFG1 |->
    dev_data[6:4] == {test_window_enable, test_pulse_analog, 1'b1}
    && dev_data[2:0] == event_slice_mask)
    else $error("window register 1 fields wrong");
  AST_MODE: assert property (wr
    && dev_addr == `RSS_REG_MODE_CTRL |->
    dev_data[1:0] == chip_mode)
    else $error("chip mode field wrong");
  AST_SLAVE: assert property (wr && (dev_addr == `RSS_REG_TX_CFG
    || dev_addr == `RSS_REG_TX_DACS) |-> role != RSS_ROLE_SLAVE)
    else $error("transmitter set up on a slave");
endmodule : rss_sequencer_checker
bind rss_sequencer rss_sequencer_checker i_chk
(
  .sys_clk(sys_clk), .rst_b(rst_b), .role(role), .chip_mode(chip_mode),
  .event_slice_mask(event_slice_mask),
  .test_pulse_analog(test_pulse_analog),
  .test_window_enable(test_window_enable), .busy(busy),
  .ready_for_triggers(ready_for_triggers), .dev_req(dev_req),
  .dev_is_cmd(dev_is_cmd), .dev_addr(dev_addr), .dev_data(dev_data),
  .dev_ack(dev_ack)
);
`default_nettype wire

// ===== verilog/rss_access_port.sv
/*
  One device access at a time: a register write or a command.
  Assumes the device raises dev_ack for one cycle per accepted access.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rss_defs.svh"
module rss_access_port
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        launch,
  input  wire logic        launch_cmd,
  input  wire logic [15:0] launch_addr,
  input  wire logic [15:0] launch_data,
  output logic             busy,
  output logic             finished,
  output logic             dev_req,
  output logic             dev_is_cmd,
  output logic [15:0]      dev_addr,
  output logic [15:0]      dev_data,
  input  wire logic        dev_ack
);

  // ----------------------------------------------------------------------
  // hold request until acknowledged
  // ----------------------------------------------------------------------
  // a launch while dev_req is high is ignored; the sequencer never does that
  wire take = launch && !dev_req;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dev_req    <= 1'b0;
      dev_is_cmd <= 1'b0;
      dev_addr   <= 16'h0000;
      dev_data   <= 16'h0000;
      finished   <= 1'b0;
    end
    else
    begin
      finished <= dev_req && dev_ack;
      if (take)
      begin
        dev_req    <= 1'b1;
        dev_is_cmd <= launch_cmd;
        dev_addr   <= launch_addr;
        dev_data   <= launch_data;
      end
      else if (dev_ack)
        dev_req <= 1'b0;
    end
  end

  assign busy = dev_req || finished;

endmodule : rss_access_port
`default_nettype wire

// ===== verilog/rss_sequencer.sv
/*
  Host-side bring-up sequencer: drives a chip through reset, pixel
  latch initialisation, transmitter start-up (inner and master chips), chain and window set-up,
  mode write and readout reset.
  Assumes a device access port with one-cycle dev_ack and a separate
  pixel latch loader answering pix_init_req with pix_init_done.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rss_defs.svh"
module rss_sequencer
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              start,
  input  wire rss_pkg::rss_role_t role,
  input  wire logic              use_load_outer,
  input  wire logic [1:0]        osc_stages,
  input  wire logic              loop_bw_wide,
  input  wire logic [3:0]        pump_current,
  input  wire logic [3:0]        line_current,
  input  wire logic [3:0]        pre_current,
  input  wire logic [3:0]        predecessor_identifier,
  input  wire logic              first_in_chain,
  input  wire logic [2:0]        event_slice_mask,
  input  wire logic              internal_windows,
  input  wire logic              test_pulse_analog,
  input  wire logic              test_window_enable,
  input  wire logic [15:0]       window_length,
  input  wire logic [15:0]       pulse_delay,
  input  wire logic [15:0]       pulse_length,
  input  wire logic [1:0]        chip_mode,
  input  wire logic              clustering,
  input  wire logic              readout_fast,
  input  wire logic [1:0]        link_speed,
  output logic                   busy,
  output logic                   ready_for_triggers,
  output logic                   config_error,
  output logic                   pix_init_req,
  input  wire logic              pix_init_done,
  output logic                   dev_req,
  output logic                   dev_is_cmd,
  output logic [15:0]            dev_addr,
  output logic [15:0]            dev_data,
  input  wire logic              dev_ack
);
  import rss_pkg::*;

  // ----------------------------------------------------------------------
  // state and latched transmitter word
  // ----------------------------------------------------------------------
  rss_state_t  state;
  rss_state_t  next_state;
  logic        issued;
  logic [15:0] tx_cfg;
  logic        port_busy;
  logic        port_done;

  // ----------------------------------------------------------------------
  // register words
  // ----------------------------------------------------------------------
  wire is_tx_chip  = (role == RSS_ROLE_INNER) || (role == RSS_ROLE_MASTER);
  wire is_inner    = (role == RSS_ROLE_INNER);
  wire mode_legal  = (chip_mode == `RSS_MODE_TRIG) ||
                     (chip_mode == `RSS_MODE_CONT); // see R16
  // continuous internal windows only meaningful in continuous mode
  wire int_win     = internal_windows &&
                     (chip_mode == `RSS_MODE_CONT); // see R12

  // power-off cleared, reset low; kept for the two reset writes
  wire [15:0] tx_cfg_word =
    (16'(osc_stages) << `RSS_TX_STAGES_LSB) |               // see R04
    (16'(loop_bw_wide) << `RSS_TX_BW_BIT);                  // see R04

  // zero pump current is not a working setting; nominal substitutes
  wire [3:0] pump_ok = (pump_current == 4'h0) ? `RSS_NOM_CP
                                              : pump_current; // see R05
  wire [15:0] dac_word =
    (16'(pump_ok)      << `RSS_DAC_CP_LSB)   |
    (16'(line_current) << `RSS_DAC_LINE_LSB) |
    (16'(pre_current)  << `RSS_DAC_PRE_LSB);

  // inner chips sit outside any chain
  wire [3:0] pred_sel  = is_inner ? `RSS_PRED_NONE
                                  : predecessor_identifier; // see R10
  wire       first_sel = is_inner ? 1'b0 : first_in_chain;  // see R08
  wire [15:0] chain_word =
    (16'(pred_sel)  << `RSS_CH_PRED_LSB) |
    (16'(first_sel) << `RSS_CH_FIRST_BIT);

  wire [15:0] strb1_word =
    (16'(event_slice_mask)   << `RSS_S1_MASK_LSB)    |      // see R11
    (16'(int_win)            << `RSS_S1_INTSTRB_BIT) |
    (16'h0001                << `RSS_S1_BUSYMON_BIT) |
    (16'(test_pulse_analog)  << `RSS_S1_PMODE_BIT)   |      // see R13
    (16'(test_window_enable) << `RSS_S1_TWIN_BIT);          // see R14

  wire [15:0] mode_word =
    (16'(chip_mode)    << `RSS_MD_MODE_LSB)    |            // see R16
    (16'(clustering)   << `RSS_MD_CLUSTER_BIT) |
    (16'(readout_fast) << `RSS_MD_SPEED_BIT)   |            // see R17
    (16'(link_speed)   << `RSS_MD_LINK_LSB);                // see R18

  // ----------------------------------------------------------------------
  // access selection per step
  // ----------------------------------------------------------------------
  logic        step_access;
  logic        step_cmd;
  logic [15:0] step_addr;
  logic [15:0] step_data;

  always_comb
  begin
    step_access = 1'b1;
    step_cmd    = 1'b0;
    step_addr   = 16'h0000;
    step_data   = 16'h0000;
    case (state)
      RSS_ST_GRST:
      begin
        step_cmd  = 1'b1;
        step_data = 16'(`RSS_CMD_GLOBAL_RST);               // see R01
      end
      RSS_ST_TXDAC:
      begin
        step_addr = `RSS_REG_TX_DACS;
        step_data = dac_word;
      end
      RSS_ST_TXCFG:
      begin
        step_addr = `RSS_REG_TX_CFG;
        step_data = tx_cfg;                                 // see R06
      end
      RSS_ST_PLLSET:
      begin
        step_addr = `RSS_REG_TX_CFG;
        step_data = tx_cfg | (16'h0001 << `RSS_TX_PLL_RST_BIT); // see R06
      end
      RSS_ST_PLLCLR:
      begin
        step_addr = `RSS_REG_TX_CFG;
        step_data = tx_cfg;                                 // see R06
      end
      RSS_ST_CHAIN:
      begin
        step_cmd  = use_load_outer;
        step_addr = `RSS_REG_CHAIN_CFG;
        step_data = use_load_outer ? 16'(`RSS_CMD_LOAD_OUTER)
                                   : chain_word;            // see R21
      end
      RSS_ST_STRB1:
      begin
        step_addr = `RSS_REG_STRB_CFG1;
        step_data = strb1_word;
      end
      RSS_ST_STRB2:
      begin
        step_addr = `RSS_REG_STRB_CFG2;
        step_data = window_length;                          // see R15
      end
      RSS_ST_PULSE1:
      begin
        step_addr = `RSS_REG_PULSE_CFG1;
        step_data = pulse_delay;                            // see R14
      end
      RSS_ST_PULSE2:
      begin
        step_addr = `RSS_REG_PULSE_CFG2;
        step_data = pulse_length;                           // see R14
      end
      RSS_ST_MODE:
      begin
        step_addr = `RSS_REG_MODE_CTRL;
        step_data = mode_word;                              // see R19
      end
      RSS_ST_READOUT_RESET_COMMAND:
      begin
        step_cmd  = 1'b1;
        step_data = 16'(`RSS_CMD_RO_RST);                   // see R20
      end
      default:
        step_access = 1'b0;
    endcase
  end

  wire launch = step_access && !issued && !port_busy;

  // ----------------------------------------------------------------------
  // step order
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      RSS_ST_IDLE:
        if (start && mode_legal)
          next_state = RSS_ST_GRST;
      RSS_ST_GRST:
        if (port_done)
          next_state = RSS_ST_PIXINIT;
      RSS_ST_PIXINIT:                                       // see R02
        if (pix_init_done)
          next_state = is_tx_chip ? RSS_ST_TXDAC
                                  : RSS_ST_CHAIN;           // see R03
      RSS_ST_TXDAC:
        if (port_done)
          next_state = RSS_ST_TXCFG;
      RSS_ST_TXCFG:
        if (port_done)
          next_state = RSS_ST_PLLSET;
      RSS_ST_PLLSET:
        if (port_done)
          next_state = RSS_ST_PLLCLR;
      RSS_ST_PLLCLR:
        if (port_done)
          next_state = RSS_ST_CHAIN;
      RSS_ST_CHAIN:
        if (port_done)
          next_state = RSS_ST_STRB1;
      RSS_ST_STRB1:
        if (port_done)
          next_state = RSS_ST_STRB2;
      RSS_ST_STRB2:
        if (port_done)
          next_state = test_window_enable ? RSS_ST_PULSE1
                                          : RSS_ST_MODE;    // see R14
      RSS_ST_PULSE1:
        if (port_done)
          next_state = RSS_ST_PULSE2;
      RSS_ST_PULSE2:
        if (port_done)
          next_state = RSS_ST_MODE;
      RSS_ST_MODE:
        if (port_done)
          next_state = RSS_ST_READOUT_RESET_COMMAND;                        // see R19
      RSS_ST_READOUT_RESET_COMMAND:
        if (port_done)
          next_state = RSS_ST_READY;                        // see R09
      RSS_ST_READY:
        if (start && mode_legal)
          next_state = RSS_ST_GRST;
      default:
        next_state = RSS_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state        <= RSS_ST_IDLE;
      issued       <= 1'b0;
      tx_cfg       <= 16'h0000;
      config_error <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      issued <= (issued || launch) && !port_done;
      if (state == RSS_ST_TXDAC)
        tx_cfg <= tx_cfg_word;
      if (start && (state == RSS_ST_IDLE || state == RSS_ST_READY))
        config_error <= !mode_legal;
    end
  end

  // pixel loader request stays high until it reports completion
  assign pix_init_req       = (state == RSS_ST_PIXINIT);
  // triggers only after readout reset has been acknowledged
  assign ready_for_triggers = (state == RSS_ST_READY);      // see R19
  assign busy               = (state != RSS_ST_IDLE) &&
                              (state != RSS_ST_READY);

  // ----------------------------------------------------------------------
  // device access port
  // ----------------------------------------------------------------------
  rss_access_port u_port
  (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .launch      (launch),
    .launch_cmd  (step_cmd),
    .launch_addr (step_addr),
    .launch_data (step_data),
    .busy        (port_busy),
    .finished    (port_done),
    .dev_req     (dev_req),
    .dev_is_cmd  (dev_is_cmd),
    .dev_addr    (dev_addr),
    .dev_data    (dev_data),
    .dev_ack     (dev_ack)
  );

endmodule : rss_sequencer
`default_nettype wire
